// file: opbk_bank.sv
// Purpose: Parameter bank of a drive option module behind an APB slave.
// Assumes: Host drive data arrives on pclk; digital inputs are pins.
// Notes: Every access takes one wait state; unmapped gives pslverr.
//
// What this block does
// - Each digital input reads 0 when its pin is low, 1 when high.
// - Each single output parameter drives its pin low on 0, high on 1.
// - Combined output bit 0 drives output 0, bit 1 drives output 1.
// - Error code reads the run-time error, 0 to 9999, never trip codes.
// - Error code clears on module reset and at program start.
// - Writing 1070 to error code restarts drive and options, clears trips.
// - Failing task code: 50 system, 1 to 10 for the ten tasks.
// - Failing task code reads zero while no error exists.
// - Encoder positions are signed 32-bit, top half 65536 per revolution.
// - Lower position half is fine position, usually zero.
// - Marker pulses never change encoder positions.
// - Each encoder has a read-only unsigned 16-bit turn count.
// - Drive mode reports the actual mode code 26, 27, 28, 29 or 20.
// - Control word loads on write; status word returns on read.
// - Control b0-b3 and b5-b8 set sequencing, preset and app bits.
// - Qualifiers b9-b12, b14, b15 load targets from b0-b3, b5, b6.
// - Control bit b13 sets application bit 3.
// - Control bit b4 trips the drive at once.
// - Status word: healthy b0, running b1, flags up to b14, b15 unused.

`timescale 1ns/1ps

module opbk_bank
  import opbk_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [OPBK_ADDR_W-1:0] paddr,
  input wire logic [OPBK_DATA_W-1:0] pwdata,
  output logic [OPBK_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital I/O pins
  input wire logic [1:0] din_pin,
  output logic [1:0] dout_pin,
  // Run-time error reports from the program processor
  input wire logic err_event,
  input wire logic [15:0] err_code_in,
  input wire logic [7:0] err_task_in,
  input wire logic prog_start,
  // Host drive data
  input wire logic pos_update,
  input wire logic [31:0] fb_pos_in,
  input wire logic [15:0] fb_turns_in,
  input wire logic [31:0] ref_pos_in,
  input wire logic [15:0] ref_turns_in,
  input wire logic [15:0] drive_mode_in,
  input wire logic [15:0] status_word_in,
  // Drive control
  output logic [15:0] ctrl_word,
  output logic ctrl_strobe,
  output logic drive_enable,
  output logic run_forward,
  output logic jog,
  output logic run_reverse,
  output logic [1:0] preset_sel,
  output logic [2:0] app_bits,
  output logic user_trip,
  output logic warm_restart
);

  // ==========================================================
  // Helper functions

  // True for any offset that holds a register
  function automatic logic opbk_addr_known(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == OPBK_DIN0_OFS) hit = 1'b1;
    else if (a == OPBK_DIN1_OFS) hit = 1'b1;
    else if (a == OPBK_DOUT0_OFS) hit = 1'b1;
    else if (a == OPBK_DOUT1_OFS) hit = 1'b1;
    else if (a == OPBK_DOUTS_OFS) hit = 1'b1;
    else if (a == OPBK_ERR_OFS) hit = 1'b1;
    else if (a == OPBK_TASK_OFS) hit = 1'b1;
    else if (a == OPBK_FBPOS_OFS) hit = 1'b1;
    else if (a == OPBK_FBTRN_OFS) hit = 1'b1;
    else if (a == OPBK_RFPOS_OFS) hit = 1'b1;
    else if (a == OPBK_RFTRN_OFS) hit = 1'b1;
    else if (a == OPBK_MODE_OFS) hit = 1'b1;
    else if (a == OPBK_CTST_OFS) hit = 1'b1;
    return hit;
  endfunction

  // Legal failing task codes; anything else is charged to the system
  function automatic logic [7:0] opbk_task_fix(input logic [7:0] t);
    logic [7:0] r;
    r = OPBK_TASK_SYSTEM;
    if (t >= OPBK_TASK_FIRST && t <= OPBK_TASK_LAST) begin
      r = t;
    end
    return r;
  endfunction

  // ==========================================================
  // Bus phase decode
  logic setup_rd;
  logic acc_done;
  logic wr_done;

  // First access cycle arms pready; the next edge completes the access
  assign setup_rd = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;
  assign wr_done = acc_done & pwrite & opbk_addr_known(paddr[7:0]);

  // ==========================================================
  // Input synchroniser
  opbk_sync_if sio ();

  assign sio.raw = din_pin;

  opbk_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sio(sio)
  );

  // ==========================================================
  // State
  logic [1:0] dout_q;
  logic [15:0] err_q;
  logic [7:0] task_q;
  logic [31:0] fb_pos_q;
  logic [15:0] fb_turns_q;
  logic [31:0] ref_pos_q;
  logic [15:0] ref_turns_q;
  logic [15:0] mode_q;
  logic [15:0] status_q;
  logic [15:0] ctrl_q;
  logic ctrl_stb_q;
  logic [3:0] seq_q;
  logic [1:0] pre_q;
  logic [2:0] app_q;
  logic trip_q;
  logic restart_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic err_resp_q;
  logic [31:0] rd_d;

  // ==========================================================
  // APB handshake: one wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_resp_q <= 1'b0;
    end else begin
      ready_q <= setup_rd;
      // Unmapped offsets answer with an error and change nothing
      err_resp_q <= setup_rd & ~opbk_addr_known(paddr[7:0]);
    end
  end

  // Read mux; narrow values sit in the low bits
  always_comb begin
    rd_d = 32'h0000_0000;
    if (paddr[7:0] == OPBK_DIN0_OFS) begin
      rd_d[0] = sio.clean[0];
    end else if (paddr[7:0] == OPBK_DIN1_OFS) begin
      rd_d[0] = sio.clean[1];
    end else if (paddr[7:0] == OPBK_DOUT0_OFS) begin
      rd_d[0] = dout_q[0];
    end else if (paddr[7:0] == OPBK_DOUT1_OFS) begin
      rd_d[0] = dout_q[1];
    end else if (paddr[7:0] == OPBK_DOUTS_OFS) begin
      rd_d[1:0] = dout_q;
    end else if (paddr[7:0] == OPBK_ERR_OFS) begin
      rd_d[15:0] = err_q;
    end else if (paddr[7:0] == OPBK_TASK_OFS) begin
      rd_d[7:0] = task_q;
    end else if (paddr[7:0] == OPBK_FBPOS_OFS) begin
      rd_d = fb_pos_q;
    end else if (paddr[7:0] == OPBK_FBTRN_OFS) begin
      rd_d[15:0] = fb_turns_q;
    end else if (paddr[7:0] == OPBK_RFPOS_OFS) begin
      rd_d = ref_pos_q;
    end else if (paddr[7:0] == OPBK_RFTRN_OFS) begin
      rd_d[15:0] = ref_turns_q;
    end else if (paddr[7:0] == OPBK_MODE_OFS) begin
      rd_d[15:0] = mode_q;
    end else if (paddr[7:0] == OPBK_CTST_OFS) begin
      rd_d[15:0] = status_q;
    end
  end

  // Read data is captured a cycle early so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_rd && !pwrite) begin
      rdata_q <= rd_d;
    end else if (acc_done) begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Digital outputs: the single and combined views share one store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= OPBK_DOUT_RST;
    end else if (wr_done) begin
      if (paddr[7:0] == OPBK_DOUT0_OFS) begin
        dout_q[0] <= pwdata[0];
      end else if (paddr[7:0] == OPBK_DOUT1_OFS) begin
        dout_q[1] <= pwdata[0];
      end else if (paddr[7:0] == OPBK_DOUTS_OFS) begin
        dout_q <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Error code and failing task
  // A new error wins over a program-start clear in the same cycle,
  // so a fault raised while starting is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= OPBK_ERR_RST;
      task_q <= OPBK_TASK_RST;
    end else if (err_event) begin
      // Codes above the range saturate rather than alias
      if (err_code_in > OPBK_ERR_MAX) begin
        err_q <= OPBK_ERR_MAX;
      end else begin
        err_q <= err_code_in;
      end
      task_q <= opbk_task_fix(err_task_in);
    end else if (prog_start) begin
      err_q <= OPBK_ERR_RST;
      task_q <= OPBK_TASK_RST;
    end else if (err_q == OPBK_ERR_RST) begin
      task_q <= OPBK_TASK_RST;
    end
  end

  // Restart key; other written values are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_done && paddr[7:0] == OPBK_ERR_OFS &&
                   pwdata[15:0] == OPBK_RESTART_KEY;
    end
  end

  // ==========================================================
  // Host drive data: positions and turns sampled only on the host's update strobe.
  // No marker input exists, so index events cannot disturb positions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_pos_q <= OPBK_POS_RST;
      ref_pos_q <= OPBK_POS_RST;
      fb_turns_q <= OPBK_WORD_RST;
      ref_turns_q <= OPBK_WORD_RST;
    end else if (pos_update) begin
      // Full word kept: coarse angle high, fine position low
      fb_pos_q <= fb_pos_in;
      ref_pos_q <= ref_pos_in;
      fb_turns_q <= fb_turns_in;
      ref_turns_q <= ref_turns_in;
    end
  end

  // Actual mode and status track the host every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= OPBK_WORD_RST;
      status_q <= OPBK_WORD_RST;
    end else begin
      mode_q <= drive_mode_in;
      status_q <= status_word_in;
      status_q[OPBK_SW_UNUSED] <= 1'b0;
    end
  end

  // ==========================================================
  // Control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= OPBK_WORD_RST;
      ctrl_stb_q <= 1'b0;
    end else begin
      ctrl_stb_q <= wr_done && paddr[7:0] == OPBK_CTST_OFS;
      if (wr_done && paddr[7:0] == OPBK_CTST_OFS) begin
        ctrl_q <= pwdata[15:0];
      end
    end
  end

  // Qualified targets load only when their qualifier is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= 4'h0;
      pre_q <= 2'h0;
      app_q <= 3'h0;
    end else if (wr_done && paddr[7:0] == OPBK_CTST_OFS) begin
      for (int i = 0; i < 4; i++) begin
        if (pwdata[OPBK_CW_QSEQ + i]) begin
          seq_q[i] <= pwdata[OPBK_CW_ENABLE + i];
        end // else hold
      end
      for (int i = 0; i < 2; i++) begin
        if (pwdata[OPBK_CW_QPRE + i]) begin
          pre_q[i] <= pwdata[OPBK_CW_PRE0 + i];
        end // else hold
      end
      app_q[0] <= pwdata[OPBK_CW_APP1];
      app_q[1] <= pwdata[OPBK_CW_APP2];
      app_q[2] <= pwdata[OPBK_CW_APP3];
    end
  end

  // User trip pulses on the write that carries b4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= wr_done && paddr[7:0] == OPBK_CTST_OFS &&
                pwdata[OPBK_CW_TRIP];
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_resp_q;
  assign dout_pin = dout_q;
  assign ctrl_word = ctrl_q;
  assign ctrl_strobe = ctrl_stb_q;
  assign drive_enable = seq_q[0];
  assign run_forward = seq_q[1];
  assign jog = seq_q[2];
  assign run_reverse = seq_q[3];
  assign preset_sel = pre_q;
  assign app_bits = app_q;
  assign user_trip = trip_q;
  assign warm_restart = restart_q;

endmodule

// file: opbk_bank_asserts.sv
// Purpose: Port-level checks for the option module parameter bank.
// Assumes: An APB access completes when psel, penable and pready are high.
// Notes: Bound to opbk_bank; looks only at the design's ports.

`timescale 1ns/1ps

module opbk_bank_asserts
  import opbk_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [OPBK_ADDR_W-1:0] paddr,
  input wire logic [OPBK_DATA_W-1:0] pwdata,
  input wire logic [OPBK_DATA_W-1:0] prdata,
  input wire logic pready,
  // Drive side
  input wire logic [1:0] dout_pin,
  input wire logic [15:0] ctrl_word,
  input wire logic ctrl_strobe,
  input wire logic drive_enable,
  input wire logic [2:0] app_bits,
  input wire logic user_trip,
  input wire logic warm_restart
);
  logic wr, rd, wr_ctl, wr_err;

  // ==========================================================
  // Completed accesses, decoded once for all checks
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign wr_ctl = wr && (paddr == OPBK_CTST_OFS);
  assign wr_err = wr && (paddr == OPBK_ERR_OFS);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Handshake and read values
  a_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_status_top: assert property (
    rd && paddr == OPBK_CTST_OFS |-> !prdata[15])
    else $error("status word bit 15 not zero");
  a_err_range: assert property (
    rd && paddr == OPBK_ERR_OFS |-> prdata <= {16'h0000, OPBK_ERR_MAX})
    else $error("error code above range");
  // Outputs follow the write that completed one edge before
  a_dout_single: assert property (
    wr && paddr == OPBK_DOUT0_OFS |=> dout_pin[0] == $past(pwdata[0]))
    else $error("output 0 pin does not follow write");
  a_dout_comb: assert property (
    wr && paddr == OPBK_DOUTS_OFS |=> dout_pin == $past(pwdata[1:0]))
    else $error("output pins do not follow combined write");
  a_restart_key: assert property (
    wr_err && pwdata == {16'h0000, OPBK_RESTART_KEY} |=> warm_restart)
    else $error("key write gave no restart");
  a_trip_cause: assert property (
    user_trip |-> $past(wr_ctl) && $past(pwdata[4]))
    else $error("user trip without a trip write");
  a_ctl_load: assert property (
    wr_ctl |=> ctrl_strobe && ctrl_word == $past(pwdata[15:0]))
    else $error("control word not loaded");
  a_qual_hold: assert property (
    wr_ctl && !pwdata[9] |=> $stable(drive_enable))
    else $error("enable moved with qualifier clear");
  a_qual_load: assert property (
    wr_ctl && pwdata[9] |=> drive_enable == $past(pwdata[0]))
    else $error("enable not loaded with qualifier set");
endmodule

bind opbk_bank opbk_bank_asserts opbk_bank_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .dout_pin(dout_pin), .ctrl_word(ctrl_word),
  .ctrl_strobe(ctrl_strobe), .drive_enable(drive_enable),
  .app_bits(app_bits), .user_trip(user_trip), .warm_restart(warm_restart)
);

// file: opbk_bank_tb.sv
// Purpose: Self-checking bench for the option module parameter bank.
// Assumes: The APB slave answers after one wait state.
// Notes: Host drive data comes from opbk_host_model.

`timescale 1ns/1ps

module opbk_bank_tb;
  import opbk_pkg::*;
  logic pclk, pready, pslverr, err, pos_update, ctrl_strobe, user_trip;
  logic drive_enable, run_forward, jog, run_reverse, warm_restart;
  logic presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic err_event = 1'h0, prog_start = 1'h0;
  logic [7:0] paddr = 8'h00, err_task_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, fb_pos_in, ref_pos_in, exp_t;
  logic [1:0] din_pin = 2'h0, dout_pin, preset_sel;
  logic [15:0] err_code_in = 16'h0, fb_turns_in, ref_turns_in, ctrl_word;
  logic [15:0] drive_mode_in, status_word_in;
  logic [15:0] modes [5] = '{OPBK_MODE_OPEN, OPBK_MODE_VECTOR,
    OPBK_MODE_SERVO, OPBK_MODE_REGEN, OPBK_MODE_OTHER};
  logic [2:0] app_bits;
  logic [8:0] ctl;
  int bad_count = 0, tests_run = 0, cycles = 0;

  // Drive command bits gathered for compact compares
  assign ctl = {drive_enable, run_forward, jog, run_reverse, preset_sel,
    app_bits};

  // ==========================================================
  // Design and host drive model
  opbk_bank opbk_bank_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .din_pin, .dout_pin,
    .err_event, .err_code_in, .err_task_in, .prog_start, .pos_update,
    .fb_pos_in, .fb_turns_in, .ref_pos_in, .ref_turns_in, .drive_mode_in,
    .status_word_in, .ctrl_word, .ctrl_strobe, .drive_enable, .run_forward,
    .jog, .run_reverse, .preset_sel, .app_bits, .user_trip, .warm_restart);
  opbk_host_model opbk_host_model_inst (.pclk, .presetn, .user_trip,
    .warm_restart, .pos_update, .fb_pos_in, .fb_turns_in, .ref_pos_in,
    .ref_turns_in, .drive_mode_in, .status_word_in);

  // 10 MHz clock
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until pready; #1 lets side pulses land
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  // Error report from the program processor
  task automatic report(input logic [15:0] c, input logic [7:0] t);
    @(posedge pclk);
    err_event <= 1'h1;
    err_code_in <= c;
    err_task_in <= t;
    @(posedge pclk);
    err_event <= 1'h0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rchk("douts", OPBK_DOUTS_OFS, 32'h0);
    rchk("err", OPBK_ERR_OFS, 32'h0);
    rchk("task", OPBK_TASK_OFS, 32'h0);
    // Pin levels, allowing for the synchroniser
    for (int i = 1; i < 3; i++) begin
      @(posedge pclk);
      din_pin <= 2'(i);
      repeat (6) @(posedge pclk);
      rchk("din0", OPBK_DIN0_OFS, 32'(i & 1));
      rchk("din1", OPBK_DIN1_OFS, 32'(i >> 1));
    end
    // Single and combined outputs share state
    apb(1'h1, OPBK_DOUT0_OFS, 32'h1);
    check("pins", dout_pin, 32'h1);
    rchk("douts", OPBK_DOUTS_OFS, 32'h1);
    apb(1'h1, OPBK_DOUTS_OFS, 32'h2);
    check("pins", dout_pin, 32'h2);
    rchk("dout0", OPBK_DOUT0_OFS, 32'h0);
    rchk("dout1", OPBK_DOUT1_OFS, 32'h1);
    // Every task code, and codes outside the list
    for (int t = 0; t < 12; t++) begin
      report(16'h0007, 8'(t));
      exp_t = (t > 0 && t < 11) ? 32'(t) : 32'(OPBK_TASK_SYSTEM);
      rchk("task", OPBK_TASK_OFS, exp_t);
    end
    // Oversize code saturates; only the key restarts
    report(16'hFFFF, 8'h03);
    rchk("err", OPBK_ERR_OFS, 32'h270F);
    apb(1'h1, OPBK_ERR_OFS, 32'h04D2);
    check("restart", warm_restart, 32'h0);
    apb(1'h1, OPBK_ERR_OFS, 32'h042E);
    check("restart", warm_restart, 32'h1);
    @(posedge pclk);
    prog_start <= 1'h1;
    @(posedge pclk);
    prog_start <= 1'h0;
    rchk("err", OPBK_ERR_OFS, 32'h0);
    rchk("task", OPBK_TASK_OFS, 32'h0);
    // Host data: mode codes, then positions with and without strobe
    foreach (modes[m]) begin
      opbk_host_model_inst.set_mode(modes[m], 16'hFFFF);
      rchk("mode", OPBK_MODE_OFS, {16'h0, modes[m]});
    end
    opbk_host_model_inst.set_pos(32'h1234_0000, 32'hFFFE_8001, 16'hFFFF,
      16'h0005, 1'h1);
    rchk("rfpos", OPBK_RFPOS_OFS, 32'hFFFE_8001);
    rchk("rftrn", OPBK_RFTRN_OFS, 32'h5);
    apb(1'h1, OPBK_FBTRN_OFS, 32'h0);
    opbk_host_model_inst.set_pos(32'h0, 32'h0, 16'h0, 16'h0, 1'h0);
    rchk("fbpos", OPBK_FBPOS_OFS, 32'h1234_0000);
    rchk("fbtrn", OPBK_FBTRN_OFS, 32'hFFFF);
    // Control word: plain loads, qualifiers, trip
    apb(1'h1, OPBK_CTST_OFS, 32'hFFEF);
    check("ctl", ctl, 32'h1FF);
    check("word", {ctrl_strobe, ctrl_word}, 32'h1FFEF);
    apb(1'h1, OPBK_CTST_OFS, 32'h0);
    check("ctl", ctl, 32'h1F8);
    apb(1'h1, OPBK_CTST_OFS, 32'h8020);
    check("ctl", ctl, 32'h1E8);
    check("trip", user_trip, 32'h0);
    apb(1'h1, OPBK_CTST_OFS, 32'h3E10);
    check("ctl", ctl, 32'h00C);
    check("trip", user_trip, 32'h1);
    rchk("status", OPBK_CTST_OFS, 32'h7FFE);
    apb(1'h1, OPBK_ERR_OFS, 32'h042E);
    rchk("status", OPBK_CTST_OFS, 32'h7FFF);
    // Unmapped offset is refused
    apb(1'h0, 8'h34, 32'h0);
    check("slverr", err, 32'h1);
    complete_run();
  end
endmodule

// file: opbk_host_model.sv
// Purpose: Host drive stand-in feeding encoder, mode and status data.
// Assumes: Bench tasks change data just after rising edges.
// Notes: A user trip drops drive healthy until a warm restart.

`timescale 1ns/1ps

module opbk_host_model
  import opbk_pkg::*;
(
  // Clock, reset and commands from the bank
  input wire logic pclk,
  input wire logic presetn,
  input wire logic user_trip,
  input wire logic warm_restart,
  // Data to the bank
  output logic pos_update,
  output logic [31:0] fb_pos_in,
  output logic [31:0] ref_pos_in,
  output logic [15:0] fb_turns_in,
  output logic [15:0] ref_turns_in,
  output logic [15:0] drive_mode_in,
  output logic [15:0] status_word_in
);
  logic tripped_q;
  logic [15:0] status_q;

  // Quiet values until the bench loads data
  initial {pos_update, fb_pos_in, ref_pos_in, fb_turns_in, ref_turns_in,
    drive_mode_in, status_q} = '0;

  // ==========================================================
  // Trip state; a restart wins so a late trip cannot stick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tripped_q <= 1'h0;
    else if (warm_restart)
      tripped_q <= 1'h0;
    else if (user_trip)
      tripped_q <= 1'h1;
  end

  // Healthy sits at bit 0
  assign status_word_in = status_q & {15'h7FFF, ~tripped_q};

  // Encoder data; the strobe is optional so stale inputs can be tested
  task automatic set_pos(input logic [31:0] fp, rp,
    input logic [15:0] ft, rt, input logic stb);
    @(posedge pclk);
    fb_pos_in <= fp;
    ref_pos_in <= rp;
    fb_turns_in <= ft;
    ref_turns_in <= rt;
    pos_update <= stb;
    @(posedge pclk);
    pos_update <= 1'h0;
  endtask

  // Actual mode and raw status
  task automatic set_mode(input logic [15:0] md, st);
    @(posedge pclk);
    drive_mode_in <= md;
    status_q <= st;
  endtask
endmodule

// file: opbk_pin_sync.sv
// Purpose: Three-stage synchroniser for the two digital input pins.
// Assumes: Pins are asynchronous to pclk.
// Notes: A level counts only when the second and third stages agree.

`timescale 1ns/1ps

module opbk_pin_sync
  import opbk_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Carrier
  opbk_sync_if.sync sio
);

  // ==========================================================
  // Stages
  logic [1:0] st1_q;
  logic [1:0] st2_q;
  logic [1:0] st3_q;
  logic [1:0] clean_q;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1_q <= OPBK_SYNC_RST;
      st2_q <= OPBK_SYNC_RST;
      st3_q <= OPBK_SYNC_RST;
    end else begin
      st1_q <= sio.raw;
      st2_q <= st1_q;
      st3_q <= st2_q;
    end
  end

  // Accept a bit only once two stages agree, rejecting one-cycle glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_q <= OPBK_SYNC_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (st2_q[i] == st3_q[i]) begin
          clean_q[i] <= st3_q[i];
        end
      end
    end
  end

  assign sio.clean = clean_q;

endmodule

// file: opbk_pkg.sv
// Purpose: Shared constants for the option module parameter bank.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; narrow values sit in the low bits.

package opbk_pkg;

  // ==========================================================
  // Bus geometry
  localparam int OPBK_ADDR_W = 8;
  localparam int OPBK_DATA_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OPBK_DIN0_OFS = 8'h00;
  localparam logic [7:0] OPBK_DIN1_OFS = 8'h04;
  localparam logic [7:0] OPBK_DOUT0_OFS = 8'h08;
  localparam logic [7:0] OPBK_DOUT1_OFS = 8'h0C;
  localparam logic [7:0] OPBK_DOUTS_OFS = 8'h10;
  localparam logic [7:0] OPBK_ERR_OFS = 8'h14;
  localparam logic [7:0] OPBK_TASK_OFS = 8'h18;
  localparam logic [7:0] OPBK_FBPOS_OFS = 8'h1C;
  localparam logic [7:0] OPBK_FBTRN_OFS = 8'h20;
  localparam logic [7:0] OPBK_RFPOS_OFS = 8'h24;
  localparam logic [7:0] OPBK_RFTRN_OFS = 8'h28;
  localparam logic [7:0] OPBK_MODE_OFS = 8'h2C;
  localparam logic [7:0] OPBK_CTST_OFS = 8'h30;

  // ==========================================================
  // Values after reset
  localparam logic [1:0] OPBK_DOUT_RST = 2'h0;
  localparam logic [15:0] OPBK_ERR_RST = 16'h0000;
  localparam logic [7:0] OPBK_TASK_RST = 8'h00;
  localparam logic [15:0] OPBK_WORD_RST = 16'h0000;
  localparam logic [31:0] OPBK_POS_RST = 32'h0000_0000;
  localparam logic [1:0] OPBK_SYNC_RST = 2'h0;

  // ==========================================================
  // Error code handling
  localparam logic [15:0] OPBK_ERR_MAX = 16'h270F;     // 9999
  localparam logic [15:0] OPBK_RESTART_KEY = 16'h042E; // 1070

  // Failing task codes
  localparam logic [7:0] OPBK_TASK_SYSTEM = 8'h32;     // 50
  localparam logic [7:0] OPBK_TASK_FIRST = 8'h01;      // Initial
  localparam logic [7:0] OPBK_TASK_LAST = 8'h0A;       // Event3

  // Actual drive mode codes
  localparam logic [15:0] OPBK_MODE_OPEN = 16'h001A;   // 26
  localparam logic [15:0] OPBK_MODE_VECTOR = 16'h001B; // 27
  localparam logic [15:0] OPBK_MODE_SERVO = 16'h001C;  // 28
  localparam logic [15:0] OPBK_MODE_REGEN = 16'h001D;  // 29
  localparam logic [15:0] OPBK_MODE_OTHER = 16'h0014;  // 20

  // ==========================================================
  // Control word field positions
  localparam int OPBK_CW_ENABLE = 0;
  localparam int OPBK_CW_FWD = 1;
  localparam int OPBK_CW_JOG = 2;
  localparam int OPBK_CW_REV = 3;
  localparam int OPBK_CW_TRIP = 4;
  localparam int OPBK_CW_PRE0 = 5;
  localparam int OPBK_CW_PRE1 = 6;
  localparam int OPBK_CW_APP1 = 7;
  localparam int OPBK_CW_APP2 = 8;
  localparam int OPBK_CW_QSEQ = 9;   // b9..b12 qualify b0..b3
  localparam int OPBK_CW_APP3 = 13;
  localparam int OPBK_CW_QPRE = 14;  // b14..b15 qualify b5..b6
  localparam int OPBK_SW_UNUSED = 15;

endpackage

// file: opbk_sync_if.sv
// Purpose: Carrier between the bank and its input synchroniser.
// Assumes: One clock domain on the bank side.
// Notes: Raw pins go in, settled levels come back.

`timescale 1ns/1ps

interface opbk_sync_if;
  logic [1:0] raw;
  logic [1:0] clean;

  // Synchroniser takes raw pins and returns settled levels
  modport sync (input raw, output clean);
  // Bank supplies raw pins and reads settled levels
  modport bank (output raw, input clean);
endinterface
